// ### prog_fetch_map.vh
`ifndef PROG_FETCH_MAP_VH
`define PROG_FETCH_MAP_VH

// Address space
`define ADDR_W            16
`define ROM_BASE_SMALL    16'hC000
`define ROM_BASE_LARGE    16'hA000
`define SFR_BASE          16'h0000
`define SFR_LAST          16'h003F
`define RAM_BASE          16'h0040
`define RAM_LAST          16'h023F
`define DBR_BASE          16'h0F80
`define DBR_LAST          16'h0FFF
`define BANK_SPAN         16'h0080
`define BANK_LSB          3
`define BANK_MSB          6

// Space codes
`define SPACE_NONE        3'h0
`define SPACE_PROG        3'h1
`define SPACE_DATA        3'h2
`define SPACE_SFR         3'h3
`define SPACE_DBR         3'h4

// Top page layout
`define PAGE_CALL_HI      8'hFF
`define VCALL_BASE        16'hFFC0
`define IVEC_BASE         16'hFFE0
`define RESET_VEC_INDEX   4'hF

// Jump arithmetic
`define REL_BASE_OFFSET   16'h0002
`define SHORT_DISP_MSB    4
`define FETCH_STEP        16'h0001

// Commands
`define OP_FETCH          3'h0
`define OP_SHORT_REL      3'h1
`define OP_BYTE_REL       3'h2
`define OP_ABS_JUMP       3'h3
`define OP_TABLE_CALL     3'h4
`define OP_PAGE_CALL      3'h5
`define OP_VECTOR         3'h6

// Reset pin drive length
`define RST_DRIVE_CYCLES  8

`endif

// ### program_fetch_address_map.v
`timescale 1ns/1ns
`include "prog_fetch_map.vh"

module program_fetch_address_map #(
  parameter LARGE_ROM        = 0,                  // 1 selects the 24 KB variant
  parameter RST_DRIVE_CYCLES = `RST_DRIVE_CYCLES   // Cycles the reset pin is pulled low
) (
  input  wire        mclk,           // Core clock, 250 MHz
  input  wire        nrst,           // Asynchronous reset, active low
  input  wire        cmd_valid,      // Command strobe, taken when busy is low
  input  wire [2:0]  cmd_op,         // Command code
  input  wire [15:0] cmd_addr,       // Address of the executing instruction
  input  wire [7:0]  cmd_disp,       // Displacement or page-call entry byte
  input  wire [15:0] cmd_target,     // Absolute jump target
  input  wire [3:0]  cmd_index,      // Table call or vector index
  input  wire        cmd_cond,       // Jump condition flag
  output reg  [15:0] rom_addr,       // Program memory address
  output reg         rom_rd,         // Program memory read strobe
  input  wire [7:0]  rom_data,       // Program memory data, one cycle after rom_rd
  output reg  [15:0] pc,             // Program counter
  output reg         busy,           // Command in progress
  output reg  [7:0]  fetch_data,     // Fetched byte
  output reg         fetch_valid,    // Fetched byte strobe
  output reg         fetch_fault,    // Fetch outside the ROM window
  output reg  [15:0] ret_addr,       // Return address for calls
  output reg         call_push,      // Return address strobe
  input  wire [15:0] data_addr,      // Load/store address to classify
  output reg  [2:0]  data_space,     // Space of data_addr
  output reg         bank_hit,       // data_addr falls in a register bank
  output reg  [3:0]  bank_sel,       // Register bank of data_addr
  input  wire        wdt_rst_req,    // Watchdog reset event
  input  wire        trap_rst_req,   // Address-trap reset event
  input  wire        clk_rst_req,    // System-clock reset event
  input  wire        rst_pin_in,     // Reset pin level
  output reg         rst_pin_out,    // Reset pin drive value
  output reg         rst_pin_oe_n,   // Reset pin enable, low while driving
  output reg         core_rst_n      // Core reset from the pin, active low
);

  // Vector loads finish four edges after the take, fetches two
  localparam S_IDLE   = 3'h0;
  localparam S_VEC    = 3'h1;
  localparam S_VEC_A  = 3'h2;
  localparam S_VEC_B  = 3'h3;
  localparam S_VEC_C  = 3'h4;
  localparam S_FETCH  = 3'h5;
  localparam S_FDATA  = 3'h6;

  localparam [15:0] ROM_BASE = LARGE_ROM ? `ROM_BASE_LARGE : `ROM_BASE_SMALL;
  localparam [7:0]  DRIVE_N  = RST_DRIVE_CYCLES[7:0];

  reg  [2:0]  state;
  reg  [15:0] vec_addr;
  reg  [7:0]  vec_lo;
  reg  [7:0]  drive_cnt;
  reg         pin_meta;
  reg         pin_sync;
  reg  [2:0]  next_space;
  wire [15:0] rel_base;
  wire [15:0] short_disp;
  wire [15:0] byte_disp;
  wire [15:0] data_off;
  wire        in_sfr;
  wire        in_ram;
  wire        in_dbr;
  wire        in_rom;
  wire        in_bank;
  wire        pc_below_rom;
  wire        rst_event;
  wire [3:0]  bank_of;
  wire [15:0] index_offset;
  wire [15:0] table_vec_addr;
  wire [15:0] intr_vec_addr;
  wire [15:0] reset_vec_addr;
  reg  [15:0] next_jump_pc;

  // Base is the instruction address plus two, wrapping freely
  assign rel_base   = cmd_addr + `REL_BASE_OFFSET;
  assign short_disp = {{11{cmd_disp[`SHORT_DISP_MSB]}}, cmd_disp[`SHORT_DISP_MSB:0]};
  assign byte_disp  = {{8{cmd_disp[7]}}, cmd_disp};
  assign data_off   = data_addr - `RAM_BASE;

  // Vector slots sit two bytes apart, low byte at the even address
  assign index_offset   = {11'h000, cmd_index, 1'b0};
  assign table_vec_addr = `VCALL_BASE + index_offset;
  assign intr_vec_addr  = `IVEC_BASE + index_offset;
  assign reset_vec_addr = `IVEC_BASE + {11'h000, `RESET_VEC_INDEX, 1'b0};

  // Space windows do not overlap, so the test order below is free
  assign in_rom       = (data_addr >= ROM_BASE);
  assign in_sfr       = (data_addr <= `SFR_LAST);
  assign in_ram       = (data_addr >= `RAM_BASE) && (data_addr <= `RAM_LAST);
  assign in_dbr       = (data_addr >= `DBR_BASE) && (data_addr <= `DBR_LAST);
  assign in_bank      = in_ram && (data_off < `BANK_SPAN);
  assign bank_of      = data_off[`BANK_MSB:`BANK_LSB];

  // Out-of-window fetches still read; the flag lets the core trap them
  assign pc_below_rom = (pc < ROM_BASE);
  assign rst_event    = wdt_rst_req || trap_rst_req || clk_rst_req;

  // Space classification of load/store addresses
  always @* begin
    if (in_rom)
      next_space = `SPACE_PROG;
    else if (in_sfr)
      next_space = `SPACE_SFR;
    else if (in_ram)
      next_space = `SPACE_DATA;
    else if (in_dbr)
      next_space = `SPACE_DBR;
    else
      next_space = `SPACE_NONE;
  end

  // Target of the single-cycle transfers; sums wrap at 16 bits, no page limits
  always @* begin
    next_jump_pc = pc;
    case (cmd_op)
      `OP_SHORT_REL: begin
        next_jump_pc = rel_base + short_disp;
      end
      `OP_BYTE_REL: begin
        next_jump_pc = rel_base + byte_disp;
      end
      `OP_ABS_JUMP: begin
        next_jump_pc = cmd_target;
      end
      `OP_PAGE_CALL: begin
        // Entries above FFBF land in the vector tables
        next_jump_pc = {`PAGE_CALL_HI, cmd_disp};
      end
      default: begin
        next_jump_pc = pc;
      end
    endcase
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_space <= `SPACE_NONE;
      bank_hit   <= 1'b0;
      bank_sel   <= 4'h0;
    end else begin
      data_space <= next_space;
      bank_hit   <= in_bank;
      bank_sel   <= bank_of;
    end
  end

  // Reset pin: synchronised input, open drive on internal events
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_meta     <= 1'b0;
      pin_sync     <= 1'b0;
      core_rst_n   <= 1'b0;
      drive_cnt    <= 8'h00;
      rst_pin_out  <= 1'b0;
      rst_pin_oe_n <= 1'b1;
    end else begin
      pin_meta    <= rst_pin_in;
      pin_sync    <= pin_meta;
      core_rst_n  <= pin_sync;
      rst_pin_out <= 1'b0;
      // Stretch a one-cycle event so the pin is seen by the outside world
      if (rst_event) begin
        drive_cnt    <= DRIVE_N;
        rst_pin_oe_n <= 1'b0;
      end else if (drive_cnt != 8'h00) begin
        drive_cnt    <= drive_cnt - 8'h01;
        rst_pin_oe_n <= (drive_cnt == 8'h01);
      end else begin
        rst_pin_oe_n <= 1'b1;
      end
    end
  end

  // Fetch and jump sequencer
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state       <= S_VEC;
      vec_addr    <= `IVEC_BASE + {11'h000, `RESET_VEC_INDEX, 1'b0};
      vec_lo      <= 8'h00;
      pc          <= 16'h0000;
      busy        <= 1'b1;
      rom_addr    <= 16'h0000;
      rom_rd      <= 1'b0;
      fetch_data  <= 8'h00;
      fetch_valid <= 1'b0;
      fetch_fault <= 1'b0;
      ret_addr    <= 16'h0000;
      call_push   <= 1'b0;
    end else if (!core_rst_n) begin
      // Held in reset by the pin; restart from the reset vector on release
      state       <= S_VEC;
      vec_addr    <= reset_vec_addr;
      busy        <= 1'b1;
      rom_rd      <= 1'b0;
      fetch_valid <= 1'b0;
      call_push   <= 1'b0;
    end else begin
      rom_rd      <= 1'b0;
      fetch_valid <= 1'b0;
      call_push   <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cmd_valid) begin
            case (cmd_op)
              `OP_FETCH: begin
                rom_addr    <= pc;
                rom_rd      <= 1'b1;
                fetch_fault <= pc_below_rom;
                pc          <= pc + `FETCH_STEP;
                busy        <= 1'b1;
                state       <= S_FETCH;
              end
              `OP_SHORT_REL: begin
                if (cmd_cond)
                  pc <= next_jump_pc;
              end
              `OP_BYTE_REL: begin
                if (cmd_cond)
                  pc <= next_jump_pc;
              end
              `OP_ABS_JUMP: begin
                pc <= next_jump_pc;
              end
              `OP_TABLE_CALL: begin
                ret_addr  <= pc;
                call_push <= 1'b1;
                vec_addr  <= table_vec_addr;
                busy      <= 1'b1;
                state     <= S_VEC;
              end
              `OP_PAGE_CALL: begin
                ret_addr  <= pc;
                call_push <= 1'b1;
                pc        <= next_jump_pc;
              end
              `OP_VECTOR: begin
                ret_addr  <= pc;
                call_push <= (cmd_index != `RESET_VEC_INDEX);
                vec_addr  <= intr_vec_addr;
                busy      <= 1'b1;
                state     <= S_VEC;
              end
              default: begin
                state <= S_IDLE;
              end
            endcase
          end
        end
        S_VEC: begin
          rom_addr <= vec_addr;
          rom_rd   <= 1'b1;
          state    <= S_VEC_A;
        end
        S_VEC_A: begin
          // Pipelined: high byte requested while low byte returns
          rom_addr <= vec_addr + `FETCH_STEP;
          rom_rd   <= 1'b1;
          state    <= S_VEC_B;
        end
        S_VEC_B: begin
          vec_lo <= rom_data;
          state  <= S_VEC_C;
        end
        S_VEC_C: begin
          pc    <= {rom_data, vec_lo};
          busy  <= 1'b0;
          state <= S_IDLE;
        end
        S_FETCH: begin
          state <= S_FDATA;
        end
        S_FDATA: begin
          fetch_data  <= rom_data;
          fetch_valid <= 1'b1;
          busy        <= 1'b0;
          state       <= S_IDLE;
        end
        default: begin
          busy  <= 1'b0;
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// ### rom_model.sv
`timescale 1ns/1ns
module rom_model (
  input  wire        mclk,      // Core clock
  input  wire        rom_rd,    // Read strobe
  input  wire [15:0] rom_addr,  // Read address
  output reg  [7:0]  rom_data   // Byte, valid the cycle after the strobe
);
  initial rom_data = 8'h00;
  // Outside a read the bus toggles, so a stale byte is never taken for data
  always @(posedge mclk) begin
    rom_data <= rom_rd ? (rom_addr[7:0] ^ 8'h5A) : ~rom_data;
  end
endmodule

// ### fetch_map_chk.sv
`timescale 1ns/1ns
`include "prog_fetch_map.vh"
module fetch_map_chk (
  input wire        mclk,          // Core clock
  input wire        nrst,          // Reset, active low
  input wire        cmd_valid,     // Command strobe
  input wire        cmd_cond,      // Jump condition
  input wire        rom_rd,        // ROM read strobe
  input wire        busy,          // Command in progress
  input wire        fetch_valid,   // Fetched byte strobe
  input wire        core_rst_n,    // Core reset, active low
  input wire        bank_hit,      // Register bank hit
  input wire        wdt_rst_req,   // Watchdog event
  input wire        trap_rst_req,  // Address-trap event
  input wire        clk_rst_req,   // System-clock event
  input wire        rst_pin_oe_n,  // Reset pin drive, active low
  input wire [2:0]  cmd_op,        // Command code
  input wire [3:0]  cmd_index,     // Table or vector index
  input wire [3:0]  bank_sel,      // Register bank
  input wire [7:0]  cmd_disp,      // Displacement
  input wire [15:0] cmd_addr,      // Instruction address
  input wire [15:0] cmd_target,    // Absolute target
  input wire [15:0] rom_addr,      // ROM address
  input wire [15:0] pc,            // Program counter
  input wire [15:0] data_addr      // Classified address
);
  wire take = cmd_valid && !busy && core_rst_n;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  fetch_addr_a: assert property (take && cmd_op == `OP_FETCH |=> rom_rd && rom_addr == $past(pc))
    else $error("fetch address differs from pc");
  fetch_done_a: assert property (take && cmd_op == `OP_FETCH |-> ##3 fetch_valid)
    else $error("fetched byte late");
  short_jump_a: assert property (take && cmd_op == `OP_SHORT_REL && cmd_cond |=>
    pc == $past(cmd_addr) + 16'h0002 + {{11{$past(cmd_disp[4])}}, $past(cmd_disp[4:0])}) else $error("short target");
  byte_jump_a: assert property (take && cmd_op == `OP_BYTE_REL && cmd_cond |=>
    pc == $past(cmd_addr) + 16'h0002 + {{8{$past(cmd_disp[7])}}, $past(cmd_disp)}) else $error("byte target");
  no_jump_a: assert property (take && (cmd_op == `OP_SHORT_REL || cmd_op == `OP_BYTE_REL) && !cmd_cond |=>
    $stable(pc)) else $error("untaken jump moved pc");
  abs_jump_a: assert property (take && cmd_op == `OP_ABS_JUMP |=> pc == $past(cmd_target))
    else $error("absolute target");
  page_call_a: assert property (take && cmd_op == `OP_PAGE_CALL |=> pc == {8'hFF, $past(cmd_disp)})
    else $error("page call target");
  table_read_a: assert property (take && cmd_op == `OP_TABLE_CALL |-> ##2 rom_rd &&
    rom_addr == 16'hFFC0 + {11'h000, $past(cmd_index, 2), 1'b0} ##1 rom_rd && rom_addr[0]) else $error("table read");
  pin_drive_a: assert property (wdt_rst_req || trap_rst_req || clk_rst_req |=> !rst_pin_oe_n)
    else $error("reset pin not driven");
  bank_map_a: assert property (data_addr >= 16'h0040 && data_addr <= 16'h00BF |=>
    bank_hit && bank_sel == ($past(data_addr[6:3]) ^ 4'h8)) else $error("bank decode");
endmodule
bind program_fetch_address_map fetch_map_chk u_chk (.mclk, .nrst, .cmd_valid, .cmd_cond, .rom_rd, .busy,
  .fetch_valid, .core_rst_n, .bank_hit, .wdt_rst_req, .trap_rst_req, .clk_rst_req, .rst_pin_oe_n, .cmd_op,
  .cmd_index, .bank_sel, .cmd_disp, .cmd_addr, .cmd_target, .rom_addr, .pc, .data_addr);

// ### tb_top.sv
`timescale 1ns/1ns
`include "prog_fetch_map.vh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
  reg         mclk = 0, nrst = 0, cmd_valid = 0, cmd_cond = 0, wdt_rst_req = 0, trap_rst_req = 0, clk_rst_req = 0;
  reg  [2:0]  cmd_op = 0;
  reg  [3:0]  cmd_index = 0;
  reg  [7:0]  cmd_disp = 0;
  reg  [15:0] cmd_addr = 0, cmd_target = 0, data_addr = 0;
  wire [15:0] rom_addr, pc, ret_addr;
  wire [7:0]  rom_data, fetch_data;
  wire [2:0]  data_space;
  wire [3:0]  bank_sel;
  wire        rom_rd, busy, fetch_valid, fetch_fault, call_push, bank_hit, rst_pin_out, rst_pin_oe_n, core_rst_n;
  wire        rst_pin_in = rst_pin_oe_n ? 1'b1 : rst_pin_out;  // Pin has a pull-up
  integer     error_cnt = 0, total_checks = 0, cyc = 0, i, k;
  reg  [59:0] rows [0:7];
  reg  [15:0] vslot [0:3];
  reg  [18:0] cls [0:3];
  always #2 mclk = ~mclk;
  program_fetch_address_map #(.LARGE_ROM(0), .RST_DRIVE_CYCLES(2)) dut (.mclk, .nrst, .cmd_valid, .cmd_op,
    .cmd_addr, .cmd_disp, .cmd_target, .cmd_index, .cmd_cond, .rom_addr, .rom_rd, .rom_data, .pc, .busy,
    .fetch_data, .fetch_valid, .fetch_fault, .ret_addr, .call_push, .data_addr, .data_space, .bank_hit,
    .bank_sel, .wdt_rst_req, .trap_rst_req, .clk_rst_req, .rst_pin_in, .rst_pin_out, .rst_pin_oe_n, .core_rst_n);
  rom_model u_rom (.mclk, .rom_rd, .rom_addr, .rom_data);
  function [15:0] vec(input [15:0] a);
    vec = {(a[7:0] + 8'h01) ^ 8'h5A, a[7:0] ^ 8'h5A};
  endfunction
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task idle;
    for (k = 0; k < 60 && busy !== 1'b0; k++) @(negedge mclk);
  endtask
  task run(input [2:0] op, input [15:0] a, input [7:0] d, input [15:0] t, input [3:0] x, input c);
    begin
      // An edge passes so cmd_valid never rises in the step where it fell
      @(negedge mclk);
      idle;
      {cmd_op, cmd_addr, cmd_disp, cmd_target, cmd_index, cmd_cond, cmd_valid} = {op, a, d, t, x, c, 1'b1};
      @(negedge mclk) cmd_valid = 0;
    end
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  initial begin
    rows[0] = {`OP_SHORT_REL, 16'hE8C4, 8'h08, 16'h0000, 1'b1, 16'hE8CE};
    rows[1] = {`OP_SHORT_REL, 16'hE8C4, 8'h1F, 16'h0000, 1'b1, 16'hE8C5};
    rows[2] = {`OP_BYTE_REL, 16'hE8C4, 8'h80, 16'h0000, 1'b1, 16'hE846};
    rows[3] = {`OP_BYTE_REL, 16'hFFF0, 8'h7F, 16'h0000, 1'b1, 16'h0071};
    rows[4] = {`OP_BYTE_REL, 16'h0071, 8'h40, 16'h0000, 1'b0, 16'h0071};
    rows[5] = {`OP_ABS_JUMP, 16'h0000, 8'h00, 16'hC235, 1'b0, 16'hC235};
    rows[6] = {`OP_PAGE_CALL, 16'hC235, 8'h7B, 16'h0000, 1'b0, 16'hFF7B};
    rows[7] = {3'h7, 16'hE8C4, 8'h08, 16'h1234, 1'b1, 16'hFF7B};
    vslot[0] = 16'hFFC0;
    vslot[1] = 16'hFFDE;
    vslot[2] = 16'hFFE4;
    vslot[3] = 16'hFFFE;
    cls[0] = {16'h0010, `SPACE_SFR};
    cls[1] = {16'h0048, `SPACE_DATA};
    cls[2] = {16'h0F90, `SPACE_DBR};
    cls[3] = {16'hC000, `SPACE_PROG};
    repeat (16) @(negedge mclk);
    nrst = 1;
    repeat (4) @(negedge mclk);
    idle;
    `CHK("reset pc", vec(16'hFFFE), pc)
    for (i = 0; i < 8; i++) begin
      run(rows[i][59:57], rows[i][56:41], rows[i][40:33], rows[i][32:17], 4'h0, rows[i][16]);
      `CHK("jump pc", rows[i][15:0], pc)
    end
    // Below the small ROM base the read still happens but is flagged
    for (i = 0; i < 2; i++) begin
      run(`OP_ABS_JUMP, 16'h0000, 8'h00, i ? 16'hC000 : 16'hA000, 4'h0, 1'b0);
      run(`OP_FETCH, 16'h0000, 8'h00, 16'h0000, 4'h0, 1'b0);
      repeat (2) @(negedge mclk);
      `CHK("fetch valid", 1'b1, fetch_valid)
      `CHK("fetch data", 8'h5A, fetch_data)
      `CHK("fetch fault", i ? 1'b0 : 1'b1, fetch_fault)
      `CHK("fetch pc", i ? 16'hC001 : 16'hA001, pc)
    end
    for (i = 0; i < 4; i++) begin
      run(i < 2 ? `OP_TABLE_CALL : `OP_VECTOR, 16'h0000, 8'h00, 16'h0000, i[0] ? 4'hF : i[3:0], 1'b0);
      `CHK("push", i != 3, call_push)
      `CHK("busy", 1'b1, busy)
      `CHK("return", i ? vec(vslot[i[1:0] - 2'h1]) : 16'hC001, ret_addr)
      idle;
      `CHK("vector pc", vec(vslot[i[1:0]]), pc)
    end
    for (i = 0; i < 4; i++) begin
      data_addr = cls[i][18:3];
      @(negedge mclk);
      `CHK("space", cls[i][2:0], data_space)
      `CHK("bank hit", i == 1, bank_hit)
      if (i == 1) `CHK("bank sel", 4'h1, bank_sel)
    end
    for (i = 0; i < 3; i++) begin
      run(`OP_ABS_JUMP, 16'h0000, 8'h00, 16'h1234, 4'h0, 1'b0);
      {wdt_rst_req, trap_rst_req, clk_rst_req} = 3'b100 >> i;
      @(negedge mclk) {wdt_rst_req, trap_rst_req, clk_rst_req} = 3'b000;
      `CHK("pin drive", 1'b0, rst_pin_oe_n)
      `CHK("pin level", 1'b0, rst_pin_out)
      for (k = 0; k < 20 && core_rst_n !== 1'b0; k++) @(negedge mclk);
      `CHK("core reset", 1'b0, core_rst_n)
      @(negedge mclk);
      idle;
      `CHK("pin reset pc", vec(16'hFFFE), pc)
    end
    tally_and_finish;
  end
endmodule
